/* hw/pmc_mdio_engine.sv */
// Serial management frame engine, sampled on the system clock
module pmc_mdio_engine #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     mdc,
  input  wire logic     mdio_in,
  output logic          mdio_out,
  output logic          mdio_oe,
  pmc_mgmt_if.engine    m
);

  typedef struct packed {
    logic [1:0]         mdc_sync;
    logic [1:0]         mdio_sync;
    logic               mdc_prev;
    pmc_pkg::pmc_state_t st;
    logic [5:0]         ones;
    logic [4:0]         cnt;
    logic [15:0]        sh;
    logic               is_read;
    logic [4:0]         regad;
    logic [15:0]        wdata;
    logic               wr;
    logic               rd;
    logic               out;
    logic               oe;
  } pmc_eng_t;

  pmc_eng_t s;
  pmc_eng_t next_s;

  always_comb begin
    logic        bit_in;
    logic [12:0] hdr;
    next_s = s;
    bit_in = s.mdio_sync[1];
    hdr    = {s.sh[11:0], bit_in};
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    // Edges found by sampling, so any management clock whose high and low phases each outlast a system clock period works
    next_s.mdc_sync  = {s.mdc_sync[0], mdc};
    next_s.mdio_sync = {s.mdio_sync[0], mdio_in};
    next_s.mdc_prev  = s.mdc_sync[1];
    if (s.mdc_sync[1] && !s.mdc_prev) begin
      case (s.st)
        pmc_pkg::PMC_PRE: begin
          if (bit_in) begin
            if (s.ones != pmc_pkg::PREAMBLE_LEN) begin
              next_s.ones = s.ones + 6'h01;
            end
          end else if (s.ones == pmc_pkg::PREAMBLE_LEN) begin
            next_s.st  = pmc_pkg::PMC_HDR;
            next_s.cnt = 5'h00;
            next_s.sh  = 16'h0000;
          end else begin
            next_s.ones = 6'h00;
          end
        end
        pmc_pkg::PMC_HDR: begin
          next_s.sh  = {s.sh[14:0], bit_in};
          next_s.cnt = s.cnt + 5'h01;
          if (s.cnt == pmc_pkg::HDR_LAST) begin
            if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                (hdr[11:10] == pmc_pkg::OP_READ || hdr[11:10] == pmc_pkg::OP_WRITE)) begin
              next_s.st      = pmc_pkg::PMC_TA;
              next_s.cnt     = 5'h00;
              next_s.is_read = (hdr[11:10] == pmc_pkg::OP_READ);
              next_s.regad   = hdr[4:0];
            end else begin
              next_s.st   = pmc_pkg::PMC_PRE;
              next_s.ones = 6'h00;
            end
          end
        end
        pmc_pkg::PMC_TA: begin
          // First turnaround bit released, second driven low on reads
          if (s.cnt == 5'h00) begin
            next_s.cnt = 5'h01;
            if (s.is_read) begin
              next_s.oe  = 1'b1;
              next_s.out = 1'b0;
            end
          end else begin
            next_s.st  = pmc_pkg::PMC_DATA;
            next_s.cnt = 5'h00;
            if (s.is_read) begin
              next_s.out = m.rdata[15];
              next_s.sh  = {m.rdata[14:0], 1'b0};
              next_s.rd  = 1'b1;
            end
          end
        end
        default: begin
          if (s.is_read) begin
            if (s.cnt == pmc_pkg::DATA_LAST) begin
              next_s.oe   = 1'b0;
              next_s.out  = 1'b0;
              next_s.st   = pmc_pkg::PMC_PRE;
              next_s.ones = 6'h00;
            end else begin
              next_s.out = s.sh[15];
              next_s.sh  = {s.sh[14:0], 1'b0};
              next_s.cnt = s.cnt + 5'h01;
            end
          end else begin
            next_s.sh = {s.sh[14:0], bit_in};
            if (s.cnt == pmc_pkg::DATA_LAST) begin
              next_s.wr    = 1'b1;
              next_s.wdata = {s.sh[14:0], bit_in};
              next_s.st    = pmc_pkg::PMC_PRE;
              next_s.ones  = 6'h00;
            end else begin
              next_s.cnt = s.cnt + 5'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mdio_out = s.out;
  assign mdio_oe  = s.oe;
  assign m.wr     = s.wr;
  assign m.rd     = s.rd;
  assign m.addr   = s.regad;
  assign m.wdata  = s.wdata;

endmodule : pmc_mdio_engine

/* hw/pmc_mgmt_if.sv */
// Register access channel between the serial engine and the register file
interface pmc_mgmt_if;
  logic        wr;
  logic        rd;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport engine (output wr, output rd, output addr, output wdata, input rdata);
  modport regs   (input wr, input rd, input addr, input wdata, output rdata);
endinterface : pmc_mgmt_if

/* hw/pmc_pkg.sv */
// Constants shared by the management and pin control block
package pmc_pkg;

  // ----------------------------------------------------------------
  // Clock rates and times
  // ----------------------------------------------------------------
  localparam int MCLK_KHZ        = 250000;
  localparam int MDC_MAX_KHZ     = 25000;
  localparam int REF_CLK_KHZ     = 25000;
  localparam int REF_TIMEOUT_NS  = 80;
  localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * (MCLK_KHZ / 1000) + 999) / 1000;
  localparam int RESET_MIN_NS    = 1000;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST     = 5'h0C;
  localparam logic [4:0] DATA_LAST    = 5'h0F;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;

  // ----------------------------------------------------------------
  // Register offsets, fields, reset values
  // ----------------------------------------------------------------
  localparam logic [4:0]  ADDR_CTRL        = 5'h00;
  localparam logic [4:0]  ADDR_STATUS      = 5'h01;
  localparam logic [4:0]  ADDR_PIN_CFG     = 5'h10;
  localparam logic [4:0]  ADDR_IRQ_MASK    = 5'h12;
  localparam logic [4:0]  ADDR_IRQ_STATUS  = 5'h13;
  localparam int          CTRL_SOFT_RST    = 15;
  localparam int          CTRL_POWER_DOWN  = 11;
  localparam int          STATUS_PD        = 2;
  localparam int          STATUS_REF_ALIVE = 1;
  localparam int          PIN_CFG_IRQ      = 0;
  localparam logic        PD_RESET         = 1'h0;
  localparam logic        PIN_IRQ_RESET    = 1'h0;
  localparam logic [15:0] MASK_RESET       = 16'h0000;

  typedef enum logic [1:0] {
    PMC_PRE  = 2'h0,
    PMC_HDR  = 2'h1,
    PMC_TA   = 2'h3,
    PMC_DATA = 2'h2
  } pmc_state_t;

endpackage : pmc_pkg

/* hw/pmc_top.sv */
// Management pins, shared interrupt or power-down pin, reset and reference clock
module pmc_top #(
  parameter int         NUM_EVENTS = 8,
  parameter logic [4:0] PHY_ADDR   = 5'h00
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  mdc,
  input  wire logic                  mdio_in,
  output logic                       mdio_out,
  output logic                       mdio_oe,
  input  wire logic                  irq_or_powerdown_pin_in,
  output logic                       irq_or_powerdown_pin_out,
  output logic                       irq_or_powerdown_pin_oe,
  input  wire logic                  reset_pin_n,
  input  wire logic                  reference_clock_input,
  input  wire logic [NUM_EVENTS-1:0] irq_events,
  output logic                       power_down,
  output logic                       core_reset,
  output logic                       ref_tick,
  output logic                       ref_alive
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            rst_sync;
    logic [1:0]            pin_sync;
    logic [1:0]            ref_sync;
    logic                  ref_prev;
    logic                  core_rst;
    logic                  soft_rst;
    logic                  pd_bit;
    logic                  pin_is_irq;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic [NUM_EVENTS-1:0] irq_stat;
    logic [4:0]            ref_age;
    logic                  ref_alive;
    logic                  ref_tick;
    logic                  power_down;
    logic                  pin_oe;
  } pmc_top_t;

  localparam logic [4:0] REF_TIMEOUT = 5'(pmc_pkg::REF_TIMEOUT_CYC);

  pmc_top_t   s;
  pmc_top_t   next_s;
  pmc_mgmt_if m ();

  // Frames keep running in power-down; only the reset clears the engine
  pmc_mdio_engine #(
    .PHY_ADDR (PHY_ADDR)
  ) u_engine (
    .mclk     (mclk),
    .rst      (s.core_rst),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .m        (m)
  );

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    m.rdata = 16'h0000;
    if (m.addr == pmc_pkg::ADDR_CTRL) begin
      m.rdata[pmc_pkg::CTRL_POWER_DOWN] = s.pd_bit;
    end else if (m.addr == pmc_pkg::ADDR_STATUS) begin
      m.rdata[pmc_pkg::STATUS_PD]        = s.power_down;
      m.rdata[pmc_pkg::STATUS_REF_ALIVE] = s.ref_alive;
    end else if (m.addr == pmc_pkg::ADDR_PIN_CFG) begin
      m.rdata[pmc_pkg::PIN_CFG_IRQ] = s.pin_is_irq;
    end else if (m.addr == pmc_pkg::ADDR_IRQ_MASK) begin
      m.rdata[NUM_EVENTS-1:0] = s.irq_mask;
    end else if (m.addr == pmc_pkg::ADDR_IRQ_STATUS) begin
      m.rdata[NUM_EVENTS-1:0] = s.irq_stat;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ref_rise;
    logic clr_stat;
    next_s   = s;
    ref_rise = s.ref_sync[1] && !s.ref_prev;
    clr_stat = m.rd && (m.addr == pmc_pkg::ADDR_IRQ_STATUS);

    // Pins pass two flops before any logic looks at them
    next_s.rst_sync = {s.rst_sync[0], reset_pin_n};
    next_s.pin_sync = {s.pin_sync[0], irq_or_powerdown_pin_in};
    next_s.ref_sync = {s.ref_sync[0], reference_clock_input};
    next_s.ref_prev = s.ref_sync[1];
    next_s.core_rst = !s.rst_sync[1];
    next_s.soft_rst = 1'b0;

    // Reference edge tick and loss watchdog
    next_s.ref_tick = ref_rise;
    if (ref_rise) begin
      next_s.ref_age   = 5'h00;
      next_s.ref_alive = 1'b1;
    end else if (s.ref_age == REF_TIMEOUT) begin
      next_s.ref_alive = 1'b0;
    end else begin
      next_s.ref_age = s.ref_age + 5'h01;
    end

    // Register writes
    if (m.wr) begin
      if (m.addr == pmc_pkg::ADDR_CTRL) begin
        next_s.pd_bit   = m.wdata[pmc_pkg::CTRL_POWER_DOWN];
        next_s.soft_rst = m.wdata[pmc_pkg::CTRL_SOFT_RST];
      end else if (m.addr == pmc_pkg::ADDR_PIN_CFG) begin
        next_s.pin_is_irq = m.wdata[pmc_pkg::PIN_CFG_IRQ];
      end else if (m.addr == pmc_pkg::ADDR_IRQ_MASK) begin
        next_s.irq_mask = m.wdata[NUM_EVENTS-1:0];
      end
    end

    // New events win over the read that clears
    next_s.irq_stat = (clr_stat ? '0 : s.irq_stat) | irq_events;

    // Pin low enters power-down only while the pin is an input
    next_s.power_down = s.pd_bit || (!s.pin_is_irq && !s.pin_sync[1]);

    // Open drain: enable only, the driven level is always low
    next_s.pin_oe = s.pin_is_irq && |(s.irq_stat & s.irq_mask);

    // Hardware or soft reset puts the registers back to default
    if (s.core_rst || s.soft_rst) begin
      next_s.pd_bit     = pmc_pkg::PD_RESET;
      next_s.pin_is_irq = pmc_pkg::PIN_IRQ_RESET;
      next_s.irq_mask   = pmc_pkg::MASK_RESET[NUM_EVENTS-1:0];
      next_s.irq_stat   = '0;
      next_s.power_down = 1'b0;
      next_s.pin_oe     = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s          <= '0;
      s.core_rst <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign irq_or_powerdown_pin_out = 1'b0;
  assign irq_or_powerdown_pin_oe  = s.pin_oe;
  assign power_down               = s.power_down;
  assign core_reset               = s.core_rst;
  assign ref_tick                 = s.ref_tick;
  assign ref_alive                = s.ref_alive;

endmodule : pmc_top

/* testbench/pmc_station.sv */
// Station model driving the management clock and data line
module pmc_station (
  output logic      mdc,
  output logic      mdio_oe,
  output logic      mdio_val,
  input  wire logic mdio
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  initial begin
    mdc = 1'b0; // Clock stands still outside frames
    mdio_oe = 1'b0;
    mdio_val = 1'b0;
  end
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] fr;
    fr = {32'hFFFFFFFF, 2'h1, op, 5'h00, ra, 2'h2, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      mdio_oe = !(op == pmc_pkg::OP_READ && i < 18);
      mdio_val = fr[i];
      #40 mdc = 1'b1;
      if (i < 16) rd[i] = mdio;
      #40 mdc = 1'b0;
    end
    mdio_oe = 1'b0;
    #40; // Idle gap keeps back-to-back frames apart
  endtask : xfer
endmodule : pmc_station

/* testbench/pmc_top_asserts.sv */
// Checker for the management and shared pin block
module pmc_top_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic irq_or_powerdown_pin_in,
  input wire logic irq_or_powerdown_pin_out,
  input wire logic irq_or_powerdown_pin_oe,
  input wire logic reset_pin_n,
  input wire logic reference_clock_input,
  input wire logic power_down,
  input wire logic core_reset,
  input wire logic ref_tick,
  input wire logic ref_alive
);
  // ----------------------------------------------------------------
  // Idle counters, saturating so long gaps stay harmless
  // ----------------------------------------------------------------
  logic [7:0] mdc_low_cnt;
  logic [7:0] ref_still_cnt;
  logic       ref_last;
  always_ff @(posedge mclk) begin
    ref_last <= reference_clock_input;
    mdc_low_cnt <= (rst || mdc) ? 8'h00 : mdc_low_cnt + {7'h00, mdc_low_cnt != 8'hFF};
    ref_still_cnt <= (rst || reference_clock_input != ref_last) ? 8'h00
                   : ref_still_cnt + {7'h00, ref_still_cnt != 8'hFF};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_rst_done; $fell(rst); endsequence
  sequence s_pin_rst; !reset_pin_n [*5]; endsequence
  sequence s_pin_quiet; reset_pin_n [*6]; endsequence
  sequence s_pd_req; $fell(core_reset) ##0 !irq_or_powerdown_pin_in [*6]; endsequence
  AST_RST_OUT: assert property (s_rst_done |-> core_reset && !mdio_oe && !power_down
    && !irq_or_powerdown_pin_oe) else $error("outputs not cleared by reset");
  AST_PIN_RST: assert property (s_pin_rst |-> core_reset) else $error("no core reset");
  AST_PIN_FREE: assert property (s_pin_quiet |-> !core_reset) else $error("stuck reset");
  AST_PD_PIN: assert property (s_pd_req |-> power_down) else $error("pin ignored");
  AST_OPEN_DRAIN: assert property (irq_or_powerdown_pin_out == 1'b0)
    else $error("shared pin driven high");
  AST_IRQ_RST: assert property (core_reset [*3] |-> !irq_or_powerdown_pin_oe)
    else $error("pin pulled while in reset");
  AST_MDIO_IDLE: assert property (mdc_low_cnt > 8'h20 |-> !mdio_oe && !mdio_out)
    else $error("data line driven between frames");
  AST_REF_TICK: assert property ($rose(reference_clock_input) |-> ##[2:6] ref_tick)
    else $error("reference edge missed");
  AST_TICK_PULSE: assert property (ref_tick |=> !ref_tick) else $error("tick too long");
  AST_REF_DEAD: assert property (ref_still_cnt > 8'h20 |-> !ref_alive)
    else $error("reference loss unseen");
endmodule : pmc_top_asserts
bind pmc_top pmc_top_asserts u_chk (.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .irq_or_powerdown_pin_in(irq_or_powerdown_pin_in),
  .irq_or_powerdown_pin_out(irq_or_powerdown_pin_out),
  .irq_or_powerdown_pin_oe(irq_or_powerdown_pin_oe), .reset_pin_n(reset_pin_n),
  .reference_clock_input(reference_clock_input), .power_down(power_down),
  .core_reset(core_reset), .ref_tick(ref_tick), .ref_alive(ref_alive));

/* testbench/pmc_top_tb_top.sv */
// Self-checking bench for the management and shared pin block
module pmc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Wiring; both shared lines have pull-ups
  // ----------------------------------------------------------------
  logic       mclk, rst, mdc, mdio_out, mdio_oe, st_oe, st_val, mdio_w, pin_w, pin_out, pin_oe;
  logic       pin_low, reset_pin_n, ref_clk, ref_en, power_down, core_reset, ref_tick, ref_alive;
  logic [7:0] irq_events;
  int         n_errors, total_checks;
  assign mdio_w = mdio_oe ? mdio_out : (st_oe ? st_val : 1'b1);
  assign pin_w = pin_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
  pmc_station u_sta (.mdc(mdc), .mdio_oe(st_oe), .mdio_val(st_val), .mdio(mdio_w));
  pmc_top u_dut (.mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .irq_or_powerdown_pin_in(pin_w), .irq_or_powerdown_pin_out(pin_out),
    .irq_or_powerdown_pin_oe(pin_oe), .reset_pin_n(reset_pin_n),
    .reference_clock_input(ref_clk), .irq_events(irq_events), .power_down(power_down),
    .core_reset(core_reset), .ref_tick(ref_tick), .ref_alive(ref_alive));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    ref_clk = 1'b0;
    forever #20 if (ref_en) ref_clk = ~ref_clk; // Stops where it stands
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_sta.xfer(pmc_pkg::OP_READ, a, 16'h0000, d);
    chk("read data", d, e);
  endtask : rd_chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    u_sta.xfer(pmc_pkg::OP_WRITE, a, d, x);
  endtask : wr
  task automatic t_defaults;
    chk("power_down", {15'h0000, power_down}, 16'h0000);
    rd_chk(pmc_pkg::ADDR_PIN_CFG, 16'h0000);
    rd_chk(pmc_pkg::ADDR_IRQ_MASK, 16'h0000);
    rd_chk(5'h1F, 16'h0000);
  endtask : t_defaults
  task automatic t_power_down;
    pin_low = 1'b1;
    cyc(8);
    chk("power_down", {15'h0000, power_down}, 16'h0001);
    rd_chk(pmc_pkg::ADDR_STATUS, 16'h0006);
    wr(pmc_pkg::ADDR_IRQ_MASK, 16'h00A5);
    rd_chk(pmc_pkg::ADDR_IRQ_MASK, 16'h00A5);
    wr(pmc_pkg::ADDR_CTRL, 16'h0800);
    pin_low = 1'b0;
    cyc(8);
    chk("power_down", {15'h0000, power_down}, 16'h0001);
    wr(pmc_pkg::ADDR_CTRL, 16'h0000);
    cyc(4);
    chk("power_down", {15'h0000, power_down}, 16'h0000);
  endtask : t_power_down
  task automatic t_irq;
    wr(pmc_pkg::ADDR_PIN_CFG, 16'h0001);
    irq_events = 8'h02;
    cyc(1);
    irq_events = 8'h00;
    cyc(4);
    chk("pin level", {15'h0000, pin_w}, 16'h0001);
    irq_events = 8'h01;
    cyc(1);
    irq_events = 8'h00;
    cyc(4);
    chk("pin level", {15'h0000, pin_w}, 16'h0000);
    chk("power_down", {15'h0000, power_down}, 16'h0000);
    rd_chk(pmc_pkg::ADDR_IRQ_STATUS, 16'h0003);
    cyc(4);
    chk("pin level", {15'h0000, pin_w}, 16'h0001);
  endtask : t_irq
  task automatic t_hw_reset;
    pin_low = 1'b1;
    reset_pin_n = 1'b0;
    cyc(250);
    chk("core_reset", {15'h0000, core_reset}, 16'h0001);
    reset_pin_n = 1'b1;
    cyc(10);
    chk("core_reset", {15'h0000, core_reset}, 16'h0000);
    chk("power_down", {15'h0000, power_down}, 16'h0001);
    pin_low = 1'b0;
    cyc(8);
    rd_chk(pmc_pkg::ADDR_IRQ_MASK, 16'h0000);
    wr(pmc_pkg::ADDR_IRQ_MASK, 16'h00A5);
    rd_chk(pmc_pkg::ADDR_IRQ_MASK, 16'h00A5);
    wr(pmc_pkg::ADDR_CTRL, 16'h8000);
    rd_chk(pmc_pkg::ADDR_IRQ_MASK, 16'h0000);
  endtask : t_hw_reset
  task automatic t_ref;
    ref_en = 1'b0;
    cyc(40);
    chk("ref_alive", {15'h0000, ref_alive}, 16'h0000);
    ref_en = 1'b1;
    cyc(40);
    chk("ref_alive", {15'h0000, ref_alive}, 16'h0001);
  endtask : t_ref
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Sequence and watchdog; about forty frames' worth of margin over the fifteen-frame run
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    pin_low = 1'b0;
    ref_en = 1'b1;
    irq_events = 8'h00;
    repeat (8) @(posedge mclk);
    #1 rst = 1'b0;
    cyc(4);
    t_defaults;
    t_power_down;
    t_irq;
    t_hw_reset;
    t_ref;
    report_and_stop;
  end
  initial begin
    #300000;
    n_errors++;
    report_and_stop;
  end
endmodule : pmc_top_tb_top
